// ---- hw/aps_pkg.sv ----
// constants for the amplifier protection and fault supervisor
// assumes a 100 MHz system clock and four half-bridge channels a..d
package aps_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned NUM_CH = 4;
    // sustained current limiting time before overload latches, in microseconds
    localparam int unsigned OVERLOAD_TIME_US = 2600;
    localparam int unsigned OVERLOAD_CYC = OVERLOAD_TIME_US * CLK_MHZ;
    // typical short check time per microfarad of filter, in milliseconds
    localparam int unsigned SHORT_MS_PER_UF = 15;
    // stuck input: longest gap between pwm edges, in microseconds
    localparam int unsigned STUCK_TIME_US = 10;
    localparam int unsigned STUCK_CYC = STUCK_TIME_US * CLK_MHZ;
    // output configuration codes
    localparam logic [1:0] CFG_BRIDGE = 2'h0;
    localparam logic [1:0] CFG_PARALLEL = 2'h1;
    localparam logic [1:0] CFG_SINGLE = 2'h2;
    localparam logic [3:0] CH_RESET = 4'h0;
    typedef enum logic [2:0] {
        APS_POWER_UP, APS_SHORT_GND, APS_SHORT_RAIL, APS_HELD, APS_START, APS_RUN
    } aps_state_e;
endpackage

// ---- hw/aps_supervisor.sv ----
// protection and fault supervisor for a four half-bridge power stage
// assumes comparator and pwm inputs synchronous enough to take through two flops
// Function
// RULE1: short check runs only after supply application
// RULE2: short found: all bridges off until cleared
// RULE3: check ground shorts first, then rail shorts
// RULE4: check steps end on done, variable length
// RULE5: during check fault low, reset ignored
// RULE6: passing check releases the fault output
// RULE7: reset never restarts the short check
// RULE8: short check skipped in single-ended mode
// RULE9: thermal warning low above warning threshold
// RULE10: thermal shutdown: all outputs off, fault low
// RULE11: thermal shutdown latched until reset
// RULE12: supply low: outputs off, fault low, self-recover
// RULE13: power-on clear resets overload state
// RULE14: stuck input silently turns channel off
// RULE15: fault and warning pins encode status
// RULE16: global fault stops all, latched until reset
// RULE17: channel fault stops only affected channels
// RULE18: reset low forces fault output high
// RULE19: reset low: off, weak pulldown unless single-ended
// RULE20: controller waits 4 ms before raising reset (the host model waits HOLD = 50 cycles)
// RULE21: reset rising edge starts up, clears overload (the code clears overload while the reset pin is held low, before the edge)
// RULE22: current limit over 2.6 ms latches overload
// RULE23: reset and comparators pass two flops
`timescale 1ns/10ps
module aps_supervisor
    import aps_pkg::*;
#(
    parameter int unsigned OVERLOAD_CYCLES = OVERLOAD_CYC
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,
    // device reset pin from the controller, active low
    input wire logic dev_reset_n,
    // configuration straps
    input wire logic [1:0] out_config,
    // analog comparators, current limit flags and pwm inputs
    input wire logic temp_warn_cmp,
    input wire logic temp_shut_cmp,
    input wire logic gate_drive_supply_ok,
    input wire logic logic_supply_ok,
    input wire logic short_gnd_cmp,
    input wire logic short_rail_cmp,
    input wire logic short_step_done,
    input wire logic [3:0] per_cycle_current_limit,
    input wire logic [3:0] pwm_in,
    // power stage control
    output logic [3:0] bridge_enable,
    output logic weak_pulldown,
    output logic startup_go,
    output logic pin_short_check,
    // status pins, open drain
    output logic fault_n_o,
    output logic fault_n_oe,
    output logic thermal_warning_n_o,
    output logic thermal_warning_n_oe,
    // status: thermal shutdown and overload latched, supply low not latched
    output logic thermal_shutdown,
    output logic supply_low_protect,
    output logic [3:0] overload_latch
);
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // every asynchronous level goes through two flops; the two cycles of
    // added reaction time are far below any analog filter window upstream
    localparam int unsigned NSYNC = 8;
    logic [NSYNC-1:0] sync1, sync2;
    wire logic [NSYNC-1:0] raw_in = {dev_reset_n, temp_warn_cmp, temp_shut_cmp,
        gate_drive_supply_ok, logic_supply_ok, short_gnd_cmp, short_rail_cmp,
        short_step_done};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= raw_in; // RULE23
            sync2 <= sync1;
        end
    end
    wire logic reset_n_s = sync2[7];
    wire logic warn_s = sync2[6];
    wire logic shut_s = sync2[5];
    wire logic supplies_ok = sync2[4] & sync2[3];
    wire logic sgnd_s = sync2[2];
    wire logic srail_s = sync2[1];
    wire logic step_done_s = sync2[0];

    // edge detector on the synchronised pin; it resets low like the pin's
    // synchroniser, so a pin held high at power-up reads as one rising edge
    logic reset_n_d;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_n_d <= 1'b0;
        end else begin
            reset_n_d <= reset_n_s;
        end
    end
    wire logic reset_rise = reset_n_s & ~reset_n_d;

    // ------------------------------------------------------------
    // start-up sequencer
    // ------------------------------------------------------------
    aps_state_e state, next_state;
    wire logic cfg_single = (out_config == CFG_SINGLE);
    wire logic in_check = (state == APS_SHORT_GND) || (state == APS_SHORT_RAIL)
        || (state == APS_HELD);
    wire logic run_ok = (state == APS_RUN);

    // the analog side decides when a check step is over, so the step
    // length follows the filter capacitance and no cycle count is kept here;
    // a short found in either step parks the sequencer until both
    // comparators are quiet, then the whole check runs again from ground
    // limitation: a comparator that never settles keeps the stage off forever
    always_comb begin
        next_state = state;
        case (state)
            APS_POWER_UP: begin
                // the check is entered only from power-up, never again
                if (supplies_ok) begin
                    next_state = cfg_single ? APS_START : APS_SHORT_GND; // RULE1 RULE8 RULE7
                end
            end
            APS_SHORT_GND: begin
                // step length set by the analog side, scaling with filter capacitance
                if (sgnd_s) begin
                    next_state = APS_HELD; // RULE2
                end else if (step_done_s) begin
                    next_state = APS_SHORT_RAIL; // RULE3 RULE4
                end
            end
            APS_SHORT_RAIL: begin
                if (srail_s) begin
                    next_state = APS_HELD; // RULE2
                end else if (step_done_s) begin
                    next_state = APS_START; // RULE6
                end
            end
            APS_HELD: begin
                if (!sgnd_s && !srail_s) begin
                    next_state = APS_SHORT_GND; // RULE2
                end
            end
            APS_START: begin
                if (reset_rise) begin
                    next_state = APS_RUN; // RULE21
                end
            end
            APS_RUN: begin
                if (!reset_n_s) begin
                    next_state = APS_START;
                end
            end
            default: next_state = APS_POWER_UP;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= APS_POWER_UP;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // latched faults
    // ------------------------------------------------------------
    // reset pin is ignored while the short check runs
    wire logic reset_held = !reset_n_s && !in_check; // RULE5
    // a new over-temperature event beats a clear in the same cycle, so a
    // hot die cannot slip out of shutdown while the reset pin is low
    logic shut_latch;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shut_latch <= 1'b0;
        end else if (shut_s) begin
            shut_latch <= 1'b1; // RULE10
        end else if (reset_held) begin
            shut_latch <= 1'b0; // RULE11
        end
    end

    // ------------------------------------------------------------
    // per channel overload and stuck input
    // ------------------------------------------------------------
    localparam int unsigned OLW = $clog2(OVERLOAD_CYCLES + 1);
    localparam int unsigned STW = $clog2(STUCK_CYC + 1);
    logic [3:0] ol_q;
    logic [3:0] stuck;
    // channel index 0..3 stands for half-bridges a..d
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [OLW-1:0] lim_cnt;
            logic [STW-1:0] idle_cnt;
            logic cl1, cl2, pw1, pw2, pw3;
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cl1 <= 1'b0;
                    cl2 <= 1'b0;
                    pw1 <= 1'b0;
                    pw2 <= 1'b0;
                    pw3 <= 1'b0;
                end else begin
                    cl1 <= per_cycle_current_limit[ch]; // RULE23
                    cl2 <= cl1;
                    pw1 <= pwm_in[ch];
                    pw2 <= pw1;
                    pw3 <= pw2;
                end
            end
            // power-on clear: async reset zeroes the overload state
            // the limit counter saturates at the trip count and restarts
            // from zero whenever limiting stops for a single cycle
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    lim_cnt <= '0; // RULE13
                    ol_q[ch] <= 1'b0; // RULE13
                end else begin
                    if (cl2 && run_ok) begin
                        if (lim_cnt != OLW'(OVERLOAD_CYCLES)) begin
                            lim_cnt <= lim_cnt + 1'b1;
                        end
                    end else begin
                        lim_cnt <= '0;
                    end
                    if (lim_cnt == OLW'(OVERLOAD_CYCLES)) begin
                        ol_q[ch] <= 1'b1; // RULE22
                    end else if (reset_held) begin
                        ol_q[ch] <= 1'b0; // RULE21
                    end
                end
            end
            // stuck input: any edge restarts the gap counter; the channel
            // comes back on its own with the first edge after the gap
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    idle_cnt <= '0;
                end else if (pw2 != pw3) begin
                    idle_cnt <= '0;
                end else if (idle_cnt != STW'(STUCK_CYC)) begin
                    idle_cnt <= idle_cnt + 1'b1;
                end
            end
            assign stuck[ch] = (idle_cnt == STW'(STUCK_CYC)); // RULE14
        end
    endgenerate

    // ------------------------------------------------------------
    // channel shutdown map
    // ------------------------------------------------------------
    // an overload latch shuts down its bridge pair; when the pairs are
    // paralleled one overloaded channel takes all four down, since the
    // two pairs then drive one shared load
    wire logic cfg_parallel = (out_config == CFG_PARALLEL);
    wire logic ol_ab = ol_q[0] | ol_q[1];
    wire logic ol_cd = ol_q[2] | ol_q[3];
    wire logic ol_all = cfg_parallel & (ol_ab | ol_cd);
    wire logic off_ab = ol_ab | ol_all;
    wire logic off_cd = ol_cd | ol_all;
    wire logic [3:0] ol_off = {off_cd, off_cd, off_ab, off_ab}; // RULE17
    // stuck inputs turn off only their own channel and raise no flag
    wire logic [3:0] chan_off = ol_off | stuck; // RULE14
    wire logic [3:0] chan_on = ~chan_off;

    // ------------------------------------------------------------
    // global shutdown
    // ------------------------------------------------------------
    // supply low is not latched: the bridges come back as soon as the
    // synchronised supply flags are high again
    wire logic supply_low = ~supplies_ok; // RULE12
    wire logic global_off = shut_latch | supply_low | ~reset_n_s; // RULE16 RULE12
    wire logic switch_ok = run_ok & ~global_off;

    // ------------------------------------------------------------
    // status pins
    // ------------------------------------------------------------
    // both pins are open drain: the data level is always low and only the
    // enable moves; the pull-ups sit outside this block
    wire logic fault_any = shut_latch | supply_low | (|ol_q);
    // a held reset pin masks every fault except the running check, which
    // ignores the reset pin altogether
    wire logic fault_low = in_check | (fault_any & reset_n_s); // RULE5 RULE18 RULE15
    // a latched shutdown also pulls the warning pin, so both pins read low unless a held reset pin masks the fault pin
    wire logic warn_low = warn_s | shut_latch; // RULE9 RULE15

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bridge_enable = switch_ok ? chan_on : CH_RESET; // RULE14 RULE19
    assign weak_pulldown = !reset_n_s && !cfg_single && !in_check; // RULE19
    assign startup_go = run_ok;
    assign pin_short_check = in_check;
    assign fault_n_o = 1'b0;
    assign fault_n_oe = fault_low; // RULE15
    assign thermal_warning_n_o = 1'b0;
    assign thermal_warning_n_oe = warn_low; // RULE9 RULE15
    assign thermal_shutdown = shut_latch;
    assign supply_low_protect = supply_low; // RULE12
    assign overload_latch = ol_q;
endmodule

// ---- bench/aps_supervisor_assertions.sv ----
// port checker for the protection supervisor
// assumes the bind at the foot of this file
`timescale 1ns/10ps
module aps_supervisor_assertions
    import aps_pkg::*;
#(
    parameter int unsigned OVERLOAD_CYCLES = OVERLOAD_CYC
) (
    // clock, resets, straps and comparators
    input wire logic clk,
    input wire logic rst_b,
    input wire logic dev_reset_n,
    input wire logic [1:0] out_config,
    input wire logic temp_warn_cmp,
    input wire logic [3:0] per_cycle_current_limit,
    // outputs watched
    input wire logic [3:0] bridge_enable,
    input wire logic weak_pulldown,
    input wire logic pin_short_check,
    input wire logic fault_n_oe,
    input wire logic thermal_warning_n_oe,
    input wire logic thermal_shutdown,
    input wire logic supply_low_protect,
    input wire logic [3:0] overload_latch
);
    logic [31:0] lim_cnt;
    // counts the raw input, so it runs ahead of the synchronised count inside
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) lim_cnt <= 32'h0;
        else if (!per_cycle_current_limit[0]) lim_cnt <= 32'h0;
        else lim_cnt <= lim_cnt + 32'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_check_fault_low: assert property (pin_short_check |-> fault_n_oe)
        else $error("fault pin released during short check");
    a_check_bridges_off: assert property (pin_short_check |-> bridge_enable == 4'h0)
        else $error("bridges on during short check");
    a_reset_fault_high: assert property ((!dev_reset_n)[*4] ##0 !pin_short_check |-> !fault_n_oe)
        else $error("fault pin low while reset held");
    a_shutdown_off: assert property (thermal_shutdown |-> bridge_enable == 4'h0 && thermal_warning_n_oe)
        else $error("bridges on in thermal shutdown");
    a_shutdown_latch: assert property ($fell(thermal_shutdown) |->
        (!$past(dev_reset_n, 2) || !$past(dev_reset_n, 3) || !$past(dev_reset_n, 4)))
        else $error("thermal shutdown cleared without reset");
    a_supply_low_off: assert property (supply_low_protect |-> bridge_enable == 4'h0)
        else $error("bridges on with supply low");
    a_overload_pair: assert property (overload_latch[0] |-> bridge_enable[1:0] == 2'h0)
        else $error("overloaded pair still on");
    a_overload_time: assert property ($rose(overload_latch[0]) |-> lim_cnt >= OVERLOAD_CYCLES)
        else $error("overload latched too early");
    a_warn_rise: assert property (temp_warn_cmp[*5] |-> thermal_warning_n_oe)
        else $error("warning pin not low when hot");
    a_warn_fall: assert property ((!temp_warn_cmp)[*5] ##0 !thermal_shutdown |-> !thermal_warning_n_oe)
        else $error("warning pin low when cool");
    a_single_no_check: assert property (out_config == CFG_SINGLE |-> !pin_short_check && !weak_pulldown)
        else $error("check or pulldown in single ended mode");
    c_check_done: cover property (pin_short_check ##1 !pin_short_check);
    c_shutdown: cover property ($rose(thermal_shutdown));
    c_overload: cover property ($rose(overload_latch[0]));
endmodule
bind aps_supervisor aps_supervisor_assertions #(.OVERLOAD_CYCLES(OVERLOAD_CYCLES)) aps_chk_i (
    .clk(clk), .rst_b(rst_b), .dev_reset_n(dev_reset_n), .out_config(out_config),
    .temp_warn_cmp(temp_warn_cmp), .per_cycle_current_limit(per_cycle_current_limit),
    .bridge_enable(bridge_enable), .weak_pulldown(weak_pulldown),
    .pin_short_check(pin_short_check), .fault_n_oe(fault_n_oe),
    .thermal_warning_n_oe(thermal_warning_n_oe), .thermal_shutdown(thermal_shutdown),
    .supply_low_protect(supply_low_protect), .overload_latch(overload_latch)
);

// ---- bench/aps_host_model.sv ----
// controller and modulator model facing the supervisor
// assumes pulled-up fault and warning pins fed in as levels
`timescale 1ns/10ps
module aps_host_model #(
    parameter int HOLD = 50
) (
    // clock and bench commands
    input wire logic clk,
    input wire logic rel,
    input wire logic pwm_stop,
    // status pins
    input wire logic fault_n,
    input wire logic warn_n,
    // drives
    output logic dev_reset_n,
    output logic [3:0] pwm_in
);
    logic f_q = 1'b1;
    int since = HOLD;
    logic [1:0] ph = 2'h0;
    initial dev_reset_n = 1'b0;
    initial pwm_in = 4'h0;
    always @(posedge clk) begin
        f_q <= fault_n;
        ph <= ph + 2'h1;
        if (!pwm_stop && ph == 2'h3) pwm_in <= ~pwm_in;
        if (f_q && !fault_n) since <= 0;
        else if (since < HOLD) since <= since + 1;
        // release only when cool and long enough after the fault fell
        if (!rel) dev_reset_n <= 1'b0;
        else if (since >= HOLD && warn_n) dev_reset_n <= 1'b1;
    end
endmodule

// ---- bench/aps_supervisor_test.sv ----
// self-checking bench for the protection supervisor
// assumes pull-ups on the fault and warning pins
`timescale 1ns/10ps
module aps_supervisor_test;
    import aps_pkg::*;
    localparam int OL = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] cfg = CFG_BRIDGE;
    logic warm = 1'b0;
    logic hot = 1'b0;
    logic gd_ok = 1'b1;
    logic sh_gnd = 1'b0;
    logic sh_rail = 1'b0;
    logic lg_ok = 1'b1;
    logic step_done = 1'b0;
    logic [3:0] cl = 4'h0;
    logic rel = 1'b0;
    logic pwm_stop = 1'b0;
    logic dev_reset_n, wpd, sg, psc, f_oe, w_oe, tsd, slp;
    logic [3:0] pwm_in, be, ol;
    wire fault_n = !f_oe;
    wire warn_n = !w_oe;
    int n_fail = 0;
    int num_checks = 0;
    aps_supervisor #(.OVERLOAD_CYCLES(OL)) aps_supervisor_i (
        .clk(clk), .rst_b(rst_b), .dev_reset_n(dev_reset_n), .out_config(cfg),
        .temp_warn_cmp(warm), .temp_shut_cmp(hot), .gate_drive_supply_ok(gd_ok),
        .logic_supply_ok(lg_ok), .short_gnd_cmp(sh_gnd), .short_rail_cmp(sh_rail),
        .short_step_done(step_done), .per_cycle_current_limit(cl), .pwm_in(pwm_in),
        .bridge_enable(be), .weak_pulldown(wpd), .startup_go(sg), .pin_short_check(psc),
        .fault_n_o(), .fault_n_oe(f_oe), .thermal_warning_n_o(), .thermal_warning_n_oe(w_oe),
        .thermal_shutdown(tsd), .supply_low_protect(slp), .overload_latch(ol));
    aps_host_model aps_host_model_i (.clk(clk), .rel(rel), .pwm_stop(pwm_stop),
        .fault_n(fault_n), .warn_n(warn_n), .dev_reset_n(dev_reset_n), .pwm_in(pwm_in));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        #1;
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
        @(posedge clk);
    endtask
    task automatic step();
        step_done <= 1'b1;
        wt(1);
        step_done <= 1'b0;
        wt(8);
    endtask
    // drop the reset pin, then let the controller raise it when allowed
    task automatic rcycle();
        rel <= 1'b0;
        wt(8);
        rel <= 1'b1;
        for (int i = 0; i < 300 && dev_reset_n !== 1'b1; i++) wt(1);
        wt(8);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #200us;
        n_fail++;
        summarize();
    end
    initial begin
        wt(5);
        rst_b <= 1'b1;
        sh_gnd <= 1'b1;
        wt(8);
        chk("check start", {psc, fault_n}, 8'h2);
        step();
        chk("held", {psc, be}, 8'h10);
        sh_gnd <= 1'b0;
        wt(8);
        step();
        chk("rail step", {psc, fault_n}, 8'h2);
        step();
        chk("check passed", {psc, fault_n}, 8'h1);
        rcycle();
        chk("run", {sg, be}, 8'h1F);
        sh_gnd <= 1'b1;
        wt(6);
        chk("late short", {psc, be}, 8'h0F);
        sh_gnd <= 1'b0;
        warm <= 1'b1;
        wt(6);
        chk("warning", {fault_n, warn_n}, 8'h2);
        warm <= 1'b0;
        wt(6);
        chk("cool", {fault_n, warn_n}, 8'h3);
        cl <= 4'h1;
        wt(OL + 10);
        chk("overload", {ol, be}, 8'h1C);
        chk("overload pins", {fault_n, warn_n}, 8'h1);
        cl <= 4'h0;
        wt(10);
        chk("overload kept", {ol, fault_n}, 8'h2);
        rcycle();
        chk("overload clear", {psc, ol, be}, 8'h0F);
        warm <= 1'b1;
        hot <= 1'b1;
        wt(6);
        hot <= 1'b0;
        warm <= 1'b0;
        wt(8);
        chk("shutdown", {tsd, be, fault_n, warn_n}, 8'h40);
        rel <= 1'b0;
        wt(8);
        chk("reset low", {fault_n, wpd, be}, 8'h30);
        rcycle();
        chk("shutdown clear", {tsd, be}, 8'h0F);
        gd_ok <= 1'b0;
        wt(6);
        chk("supply low", {slp, be, fault_n}, 8'h20);
        gd_ok <= 1'b1;
        wt(8);
        chk("supply back", {slp, be}, 8'h0F);
        lg_ok <= 1'b0;
        wt(6);
        chk("logic supply low", {slp, be}, 8'h10);
        lg_ok <= 1'b1;
        pwm_stop <= 1'b1;
        wt(1010);
        chk("stuck", {be, fault_n}, 8'h01);
        pwm_stop <= 1'b0;
        wt(10);
        chk("pwm back", be, 8'h0F);
        cfg <= CFG_PARALLEL;
        sh_rail <= 1'b1;
        rel <= 1'b0;
        rst_b <= 1'b0;
        wt(5);
        rst_b <= 1'b1;
        wt(8);
        step();
        chk("rail short", {psc, be}, 8'h10);
        sh_rail <= 1'b0;
        wt(8);
        step();
        step();
        chk("parallel start", {psc, fault_n}, 8'h1);
        rcycle();
        chk("parallel run", be, 8'h0F);
        cl <= 4'h4;
        wt(OL + 10);
        chk("parallel overload", {ol, be}, 8'h40);
        cl <= 4'h0;
        cfg <= CFG_SINGLE;
        rel <= 1'b0;
        rst_b <= 1'b0;
        wt(5);
        rst_b <= 1'b1;
        wt(10);
        chk("single ended", {psc, wpd}, 8'h0);
        summarize();
    end
endmodule
